// [dv/center_pwm_complementary_deadtime_tb.sv]
/* self-checking bench for the pwm core; drives bus and time base itself */
`timescale 1ns/1ns
module center_pwm_complementary_deadtime_tb;
   logic core_clk_in = 0;
   logic rst_in = 1;
   cpw_pkg::cpw_avmm_req_s rq = '0;
   cpw_pkg::cpw_timebase_s tb = '0;
   cpw_pkg::cpw_tb_load_s tl;
   logic [31:0] rd;
   logic wr;
   logic [5:0] pwm;
   int ovl, n, o, miscompares = 0, tests_run = 0;
   cpw_pwm_core DUT (.core_clk_in(core_clk_in), .rst_in(rst_in), .avs_req_in(rq),
      .avs_readdata_out(rd), .avs_waitrequest_out(wr), .timebase_in(tb),
      .tb_load_out(tl), .pwm_out(pwm));
   cpw_half_bridge u_hb (.core_clk_in(core_clk_in), .gate_in(pwm), .overlap_out(ovl));
   initial forever #5 core_clk_in = ~core_clk_in;
   task automatic final_report;
      if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic chk_rng(string s, int lo, int hi, int g);
      chk(s, 1, g >= lo && g <= hi);
   endtask
   task automatic bus(logic w, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
      int k;
      @(posedge core_clk_in);
      rq <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
      for (k = 0; k < 50; k++) begin
         @(posedge core_clk_in);
         if (wr === 1'b0) break;
      end
      if (k == 50) begin
         chk("bus", 0, 1);
         final_report();
      end
      q = rd;
      rq <= '0;
   endtask
   task automatic duty(int p, logic [13:0] v);
      @(posedge core_clk_in);
      tb.duty[p] <= v;
   endtask
   task automatic wait_pin(int i);
      for (n = 0; pwm[i] !== 1'b1; n++) begin
         @(posedge core_clk_in);
         if (n > 2000) begin
            chk("pin", 0, 1);
            final_report();
         end
      end
   endtask
   logic [31:0] q;
   logic [1:0] sel;
   task automatic sc_regs;
      bus(0, 4'h0, 0, q); chk("dtc", 0, q);
      bus(0, 4'h4, 0, q); chk("cfg", 0, q);
      bus(1, 4'hc, 32'h0000_00ff, q); bus(0, 4'hc, 0, q); chk("unmapped", 0, q);
      bus(1, 4'h0, 32'h0000_00c5, q); bus(0, 4'h0, 0, q); chk("dtc", 32'h0000_00c5, q);
      bus(1, 4'h0, 0, q);
   endtask
   task automatic sc_map;
      for (int p = 0; p < 3; p++) begin
         duty(p, 14'h0078);
         repeat (4) @(posedge core_clk_in);
         chk("map", 6'h15 ^ (6'h03 << 2 * p), pwm);
         duty(p, 14'h0000);
      end
   endtask
   // dead-time prescale 4..16 on a slow time base, and divide 2 and divide 4 on a 1:1 time base
   task automatic sc_dead;
      for (int s = 0; s < 5; s++) begin
         sel = (s == 4) ? 2'h1 : s[1:0];
         bus(1, 4'h0, {24'h00_0000, sel, 6'h03}, q);
         tb.prescale <= (s == 4) ? 2'h0 : sel;
         o = ovl;
         duty(0, 14'h0078);
         wait_pin(1);
         chk_rng("on", 6 << sel, (6 << sel) + 8, n);
         duty(0, 14'h0000);
         wait_pin(0);
         chk_rng("off", 6 << sel, (6 << sel) + 8, n);
         chk("ovl", o, ovl);
      end
   endtask
   task automatic sc_center;
      bus(1, 4'h0, 0, q);
      @(posedge core_clk_in);
      tb.prescale <= 2'h1;
      tb.start <= 1'b1;
      tb.count <= 12'h014;
      @(posedge core_clk_in);
      tb.start <= 1'b0;
      @(posedge core_clk_in);
      chk("load", 32'h0000_3014, {tl.load, tl.count_down, tl.value});
      duty(0, 14'h0014);
      for (int i = 0; i <= 40; i++) begin
         tb.count <= i <= 20 ? 20 - i : i - 20;
         tb.direction <= i < 20;
         repeat (4) @(posedge core_clk_in);
         if (i % 10 == 0) chk("center", i == 20, pwm[1]);
      end
   endtask
   task automatic sc_mode;
      bus(1, 4'h4, 1, q);
      duty(0, 14'h0078);
      repeat (4) @(posedge core_clk_in);
      chk("indep", 3, pwm[1:0]);
      bus(0, 4'h8, 0, q);
      chk("status", 32'h0000_0217, q);
      duty(0, 14'h0000);
      bus(1, 4'h4, 0, q);
      repeat (4) @(posedge core_clk_in);
      chk("comp", 1, pwm[1:0]);
   endtask
   // reset in mid-run returns pairs to complementary mode and clears dead time
   task automatic sc_reset;
      bus(1, 4'h4, 32'h0000_0007, q);
      bus(1, 4'h0, 32'h0000_0045, q);
      @(posedge core_clk_in);
      rst_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      rst_in <= 1'b0;
      bus(0, 4'h4, 0, q);
      chk("cfg", 0, q);
      bus(0, 4'h0, 0, q);
      chk("dtc", 0, q);
   endtask
   initial begin
      tb.period <= 12'h014;
      repeat (10) @(posedge core_clk_in);
      rst_in <= 0;
      sc_regs();
      sc_map();
      sc_dead();
      sc_center();
      sc_mode();
      sc_reset();
      final_report();
   end
endmodule

// [dv/cpw_half_bridge.sv]
/* half-bridge switch model on the six pins; assumes odd pin drives the upper switch */
`timescale 1ns/1ns
module cpw_half_bridge (
   input wire logic core_clk_in,
   input wire logic [5:0] gate_in,
   output int overlap_out
);
   initial overlap_out = 0;
   // adds one for each leg that has both switches on in a cycle, summed over the three legs
   always @(posedge core_clk_in)
      for (int k = 0; k < 3; k++)
         if (gate_in[2*k+1] && gate_in[2*k])
            overlap_out++;
endmodule

// [dv/cpw_pwm_core_assertions.sv]
/* checker for the pwm core ports; assumes one clock and sync reset */
`timescale 1ns/1ns
module cpw_pwm_core_assertions (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire cpw_pkg::cpw_avmm_req_s avs_req_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire cpw_pkg::cpw_timebase_s timebase_in,
   input wire cpw_pkg::cpw_tb_load_s tb_load_out,
   input wire logic [cpw_pkg::OUTS-1:0] pwm_out
);
   logic [1:0] ph;
   logic cf;
   logic cfd;
   logic dnz;
   logic m0;
   logic rq;
   logic wt;
   assign rq = avs_req_in.read || avs_req_in.write;
   assign wt = avs_req_in.write && !avs_waitrequest_out && avs_req_in.byteenable[0];
   assign m0 = timebase_in.duty[0] != 0 && timebase_in.duty[0][13:2] < timebase_in.period
      && timebase_in.duty[0][13:2] == timebase_in.count
      && ph == (timebase_in.prescale == 2'h0 ? timebase_in.duty[0][1:0] : 2'h0);
   always_ff @(posedge core_clk_in) begin
      ph <= rst_in ? 2'h0 : ph + 2'h1;
      cfd <= cf;
      if (rst_in) begin
         cf <= 1'b0;
         dnz <= 1'b0;
      end else if (wt && avs_req_in.address == cpw_pkg::OFS_OUTCFG) begin
         cf <= avs_req_in.writedata[0];
      end else if (wt && avs_req_in.address == cpw_pkg::OFS_DEADTIME) begin
         dnz <= avs_req_in.writedata[5:0] != 6'h00;
      end
   end
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   property p_bus_wait; rq && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
   a_bus_wait: assert property (p_bus_wait) else $error("wait over one cycle");
   property p_bus_idle; !rq |-> !avs_waitrequest_out; endproperty
   a_bus_idle: assert property (p_bus_idle) else $error("wait without request");
   property p_start;
      timebase_in.start |=> tb_load_out.load && tb_load_out.count_down
         && tb_load_out.value == $past(timebase_in.period);
   endproperty
   a_start: assert property (p_start) else $error("start load wrong");
   property p_act_down; m0 && timebase_in.direction && !cf |=> !pwm_out[0]; endproperty
   a_act_down: assert property (p_act_down) else $error("down match");
   property p_inact_up; m0 && !timebase_in.direction |=> !pwm_out[1]; endproperty
   a_inact_up: assert property (p_inact_up) else $error("up match");
   property p_zero; (timebase_in.duty[0] == 0) [*2] |=> !pwm_out[1]; endproperty
   a_zero: assert property (p_zero) else $error("zero duty active");
   property p_full;
      (timebase_in.duty[0] != 0 && timebase_in.duty[0][13:2] >= timebase_in.period && !cf) [*2]
         |=> !pwm_out[0];
   endproperty
   a_full: assert property (p_full) else $error("full duty");
   property p_overlap; !cf && !cfd |-> !(pwm_out[1] && pwm_out[0]); endproperty
   a_overlap: assert property (p_overlap) else $error("pair overlap");
   property p_off_first; dnz && !cf && !cfd && $fell(pwm_out[1]) |-> !pwm_out[0] ##1 !pwm_out[0];
   endproperty
   a_off_first: assert property (p_off_first) else $error("no dead time");
   c_down: cover property (m0 && timebase_in.direction);
   c_load: cover property (tb_load_out.load);
   c_dead: cover property (dnz && $rose(pwm_out[0]));
endmodule
bind cpw_pwm_core cpw_pwm_core_assertions u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
   .avs_req_in(avs_req_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .timebase_in(timebase_in),
   .tb_load_out(tb_load_out), .pwm_out(pwm_out));

// [hdl/cpw_pkg.sv]
/*
 * shared constants, types and register layout of the center-aligned
 * complementary pwm output stage with dead-time insertion.
 * assumes one 100 MHz core clock that stands for the oscillator.
 */
package cpw_pkg;

   // ****************************************************************
   // widths and counts
   // ****************************************************************
   localparam int PAIRS = 3;
   localparam int OUTS = 6;
   localparam int DUTY_W = 14;
   localparam int TMR_W = 12;
   localparam int DT_W = 6;
   localparam int PS_W = 4;
   localparam int ADDR_W = 4;

   // ****************************************************************
   // register offsets (byte addresses)
   // ****************************************************************
   localparam logic [ADDR_W-1:0] OFS_DEADTIME = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_OUTCFG = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int DT_PS_HI = 7;
   localparam int DT_PS_LO = 6;
   localparam int DT_CNT_HI = 5;
   localparam int DT_CNT_LO = 0;
   localparam int STAT_BUSY_LO = 6;
   localparam int STAT_CMP_LO = 9;
   localparam logic [7:0] DEADTIME_RST = 8'h00;
   localparam logic [PAIRS-1:0] OUTCFG_RST = 3'h0;

   // ****************************************************************
   // phases, prescale selects and dead-time divider terminal counts
   // ****************************************************************
   localparam logic [1:0] PHASE_Q1 = 2'h0;
   localparam logic [1:0] TB_PS_1TO1 = 2'h0;
   localparam logic [1:0] DT_PS_DIV2 = 2'h0;
   localparam logic [PS_W-1:0] DT_LAST_DIV2 = 4'h1;
   localparam logic [PS_W-1:0] DT_LAST_DIV4 = 4'h3;
   localparam logic [PS_W-1:0] DT_LAST_DIV8 = 4'h7;
   localparam logic [PS_W-1:0] DT_LAST_DIV16 = 4'hf;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } cpw_avmm_req_s;

   typedef struct packed {
      logic [TMR_W-1:0] count;
      logic [TMR_W-1:0] period;
      logic direction;
      logic [1:0] prescale;
      logic start;
      logic [PAIRS-1:0][DUTY_W-1:0] duty;
   } cpw_timebase_s;

   typedef struct packed {
      logic load;
      logic [TMR_W-1:0] value;
      logic count_down;
   } cpw_tb_load_s;

   typedef struct packed {
      logic [1:0] phase;
      logic [7:0] deadtime_control;
      logic [PAIRS-1:0] pair_mode_select;
      logic [PAIRS-1:0] cmp;
      logic [PAIRS-1:0][DT_W-1:0] dt_cnt;
      logic [PAIRS-1:0][PS_W-1:0] dt_ps;
      logic [OUTS-1:0] pwm;
      logic ack;
      logic [31:0] rdata;
      cpw_tb_load_s tb_load;
   } cpw_state_s;

endpackage

// [hdl/cpw_pwm_core.sv]
/*
 * center-aligned compare, complementary pair mapping and per-pair
 * dead-time generators, with an avalon-mm register slave.
 * assumes the time base (count, period, direction, prescale, duty
 * values) comes from logic on the same clock, and that the clock
 * stands for the oscillator, four clocks making one q1..q4 cycle.
 */
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
// Operation
// - counting down with flag 1, duty match drives compare active.
// - counting up with flag 0, duty match drives compare inactive.
// - zero duty holds output inactive whole period.
// - duty at or above period holds output active whole period.
// - on start, period is loaded into timer which counts down.
// - duty zero feeds pair 1/0, one feeds 3/2, two feeds 5/4.
// - odd outputs follow compare, even outputs are its complement.
// - clear mode bit gives complementary pair; reset clears all mode bits.
// - each pair owns a 6-bit dead-time down counter.
// - every compare edge loads the dead-time value into the counter.
// - one transition waits for counter zero, both outputs inactive meanwhile.
// - dead-time register: prescale bits 7-6, count bits 5-0, reset zero.
// - dead-time clock is oscillator over 2, 4, 8 or 16.
// - prescaler cleared on counter load, dead-time register write and reset.
// - slow time base with divide 4..16: decrement on q1.
// - 1:1 time base, divide 2: decrement every other phase by match parity.
// - 1:1 time base, divide 4..16: decrement on match phase.
// - dead time equals count times prescale over oscillator.
// - duty low bits pick match phase q1..q4; code does so on a 1:1 time base only, else matches on q1.
`timescale 1ns/1ns

module cpw_pwm_core (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // avalon-mm slave
   input wire cpw_pkg::cpw_avmm_req_s avs_req_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // time base
   input wire cpw_pkg::cpw_timebase_s timebase_in,
   output cpw_pkg::cpw_tb_load_s tb_load_out,
   // pwm pins
   output logic [cpw_pkg::OUTS-1:0] pwm_out
);

   // ****************************************************************
   // decode helpers
   // ****************************************************************
   function automatic logic [cpw_pkg::PS_W-1:0] dt_last(input logic [1:0] sel);
      logic [cpw_pkg::PS_W-1:0] r;
      r = cpw_pkg::DT_LAST_DIV2;
      case (sel)
         2'h0: r = cpw_pkg::DT_LAST_DIV2;
         2'h1: r = cpw_pkg::DT_LAST_DIV4;
         2'h2: r = cpw_pkg::DT_LAST_DIV8;
         2'h3: r = cpw_pkg::DT_LAST_DIV16;
         default: r = cpw_pkg::DT_LAST_DIV2;
      endcase
      return r;
   endfunction

   // phase on which a duty match counts
   function automatic logic match_phase(input logic [1:0] low, input logic [1:0] ph,
                                        input logic [1:0] tbps);
      logic r;
      r = 1'b0;
      if (tbps == cpw_pkg::TB_PS_1TO1) begin
         r = (ph == low);
      end else begin
         r = (ph == cpw_pkg::PHASE_Q1);
      end
      return r;
   endfunction

   // phase on which the dead-time counter may step
   function automatic logic step_phase(input logic [1:0] low, input logic [1:0] ph,
                                       input logic [1:0] tbps, input logic [1:0] dtps);
      logic r;
      r = 1'b0;
      if (tbps == cpw_pkg::TB_PS_1TO1) begin
         if (dtps == cpw_pkg::DT_PS_DIV2) begin
            r = (ph[0] == low[0]);
         end else begin
            r = (ph == low);
         end
      end else if (dtps == cpw_pkg::DT_PS_DIV2) begin
         r = 1'b1;
      end else begin
         r = (ph == cpw_pkg::PHASE_Q1);
      end
      return r;
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   cpw_pkg::cpw_state_s s;
   cpw_pkg::cpw_state_s next_s;

   logic req_any;
   logic [cpw_pkg::DUTY_W-1:0] duty;
   logic [cpw_pkg::TMR_W-1:0] duty_hi;
   logic cmp_n;
   logic [1:0] dtps;
   logic [cpw_pkg::DT_W-1:0] dtval;
   logic dt_wr;

   assign req_any = avs_req_in.read | avs_req_in.write;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      next_s = s;
      duty = '0;
      duty_hi = '0;
      cmp_n = 1'b0;
      dtps = s.deadtime_control[cpw_pkg::DT_PS_HI:cpw_pkg::DT_PS_LO];
      dtval = s.deadtime_control[cpw_pkg::DT_CNT_HI:cpw_pkg::DT_CNT_LO];
      dt_wr = 1'b0;

      // q1..q4 phase of the instruction cycle
      next_s.phase = s.phase + 2'h1;

      // time-base restart: load period and count down
      next_s.tb_load.load = timebase_in.start;
      next_s.tb_load.value = timebase_in.period;
      next_s.tb_load.count_down = timebase_in.start;

      // register bus: one wait cycle, then answer
      next_s.ack = req_any & ~s.ack;
      if (req_any && !s.ack) begin
         next_s.rdata = '0;
         if (avs_req_in.read) begin
            case (avs_req_in.address)
               cpw_pkg::OFS_DEADTIME: next_s.rdata[7:0] = s.deadtime_control;
               cpw_pkg::OFS_OUTCFG: next_s.rdata[cpw_pkg::PAIRS-1:0] = s.pair_mode_select;
               cpw_pkg::OFS_STATUS: begin
                  next_s.rdata[cpw_pkg::OUTS-1:0] = s.pwm;
                  for (int i = 0; i < cpw_pkg::PAIRS; i++) begin
                     next_s.rdata[cpw_pkg::STAT_BUSY_LO + i] = (s.dt_cnt[i] != '0);
                     next_s.rdata[cpw_pkg::STAT_CMP_LO + i] = s.cmp[i];
                  end
               end
               default: next_s.rdata = '0;
            endcase
         end
      end
      if (avs_req_in.write && s.ack && avs_req_in.byteenable[0]) begin
         case (avs_req_in.address)
            cpw_pkg::OFS_DEADTIME: begin
               next_s.deadtime_control = avs_req_in.writedata[7:0];
               dt_wr = 1'b1;
            end
            cpw_pkg::OFS_OUTCFG: begin
               next_s.pair_mode_select = avs_req_in.writedata[cpw_pkg::PAIRS-1:0];
            end
            default: dt_wr = 1'b0;
         endcase
      end

      // ****************************************************************
      // per pair: compare, dead time, pins
      // ****************************************************************
      for (int i = 0; i < cpw_pkg::PAIRS; i++) begin
         duty = timebase_in.duty[i];
         duty_hi = duty[cpw_pkg::DUTY_W-1:2];
         cmp_n = s.cmp[i];
         if (duty == '0) begin
            cmp_n = 1'b0;
         end else if (duty_hi >= timebase_in.period) begin
            cmp_n = 1'b1;
         end else if ((duty_hi == timebase_in.count)
                      && match_phase(duty[1:0], s.phase, timebase_in.prescale)) begin
            cmp_n = timebase_in.direction;
         end
         next_s.cmp[i] = cmp_n;

         // dead-time counter and its prescaler
         if (cmp_n != s.cmp[i]) begin
            next_s.dt_cnt[i] = dtval;
            next_s.dt_ps[i] = '0;
         end else if (dt_wr) begin
            next_s.dt_ps[i] = '0;
         end else if (s.dt_cnt[i] != '0) begin
            if (s.dt_ps[i] == dt_last(dtps)) begin
               if (step_phase(duty[1:0], s.phase, timebase_in.prescale, dtps)) begin
                  next_s.dt_cnt[i] = s.dt_cnt[i] - 6'h01;
                  next_s.dt_ps[i] = '0;
               end
            end else begin
               next_s.dt_ps[i] = s.dt_ps[i] + 4'h1;
            end
         end

         // pins: odd primary, even complement; with the mode bit set both follow compare
         if (s.pair_mode_select[i]) begin
            next_s.pwm[2*i+1] = cmp_n;
            next_s.pwm[2*i] = cmp_n;
         end else begin
            next_s.pwm[2*i+1] = cmp_n & (next_s.dt_cnt[i] == '0);
            next_s.pwm[2*i] = ~cmp_n & (next_s.dt_cnt[i] == '0);
         end
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         s <= '0;
         s.deadtime_control <= cpw_pkg::DEADTIME_RST;
         s.pair_mode_select <= cpw_pkg::OUTCFG_RST;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign avs_waitrequest_out = req_any & ~s.ack;
   assign avs_readdata_out = s.rdata;
   assign tb_load_out = s.tb_load;
   assign pwm_out = s.pwm;

endmodule
